// ---- verilog/lmsfc_ctrl.sv ----
// Purpose: scan limit, per digit brightness, glyph ram behind one port
// Assumes: registers written by the serial engine on clock_i; mux clock pin raw
// Notes:   one scan = 2800 mux clock rising edges, two slots of 1400
`timescale 1ns/1ps
`include "lmsfc_map.svh"
module lmsfc_ctrl (
	// clock and reset
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	// register access from the serial engine
	input  wire lmsfc_pkg::lmsfc_req_s req_i,
	output logic [7:0]                rdata_o,
	output logic                      rvalid_o,
	// multiplex clock pin, asynchronous
	input  wire logic                 mux_clock_pin_i,
	// digit enables
	output logic [3:0]                digit_en_o
);
	lmsfc_pkg::lmsfc_slot_e slot_q;
	logic [2:0]  mux_sync_q;
	logic        mux_tick;
	logic [10:0] slot_cnt_q;
	logic [7:0]  brt_lo_q, brt_hi_q;
	logic        scan_q;
	logic [3:0]  act_brt_q [4];
	logic        act_scan_q;
	logic [7:0]  ptr_q;
	logic [6:0]  glyph_mem [`LMSFC_GLYPH_DEPTH];
	logic        g_wr, g_rd, g_ptr, g_data;
	logic [7:0]  ptr_next;
	logic [3:0]  on_steps [4];
	logic [3:0]  step_now;
	logic        slot_end;

	////////////////////////////////////////////////////////////////////
	// mux clock sync and rising edge tick
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			mux_sync_q <= 3'h0;
		end else begin
			mux_sync_q <= {mux_sync_q[1:0], mux_clock_pin_i};
		end
	end
	assign mux_tick = mux_sync_q[1] & ~mux_sync_q[2];

	////////////////////////////////////////////////////////////////////
	// register writes; address 0x00 and others fall through untouched
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			brt_lo_q <= `LMSFC_RST_BRT;
			brt_hi_q <= `LMSFC_RST_BRT;
			scan_q   <= 1'b0;
		end else if (req_i.wr) begin
			case (req_i.addr)
				`LMSFC_ADDR_BRT_LO: brt_lo_q <= req_i.data;
				`LMSFC_ADDR_BRT_HI: brt_hi_q <= req_i.data;
				`LMSFC_ADDR_SCAN: scan_q <= req_i.data[`LMSFC_SCAN_BIT];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// glyph port decode
	assign g_wr   = req_i.wr && req_i.addr == `LMSFC_ADDR_GLYPH;
	assign g_rd   = req_i.rd && req_i.addr == `LMSFC_ADDR_GLYPH;
	assign g_ptr  = g_wr & req_i.data[7];
	assign g_data = (g_wr & ~req_i.data[7]) | g_rd;
	// advance with wrap past the last location
	assign ptr_next = (ptr_q >= `LMSFC_PTR_LAST) ? `LMSFC_PTR_FIRST : ptr_q + 8'h01;

	// glyph pointer; bases 0x80 + 5n fall out of linear addressing
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ptr_q <= `LMSFC_PTR_FIRST;
		end else if (g_ptr) begin
			ptr_q <= (req_i.data > `LMSFC_PTR_LAST) ? `LMSFC_PTR_FIRST : req_i.data;
		end else if (g_data) begin
			ptr_q <= ptr_next;
		end
	end

	// glyph storage, seven bits per entry
	always_ff @(posedge clock_i) begin
		if (g_wr && !req_i.data[7]) begin
			glyph_mem[7'(ptr_q - `LMSFC_PTR_FIRST)] <= req_i.data[6:0];
		end
	end

	// read data, top bit clear on glyph reads
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= req_i.rd;
			if (g_rd) begin
				rdata_o <= {1'b0, glyph_mem[7'(ptr_q - `LMSFC_PTR_FIRST)]};
			end else if (req_i.rd) begin
				case (req_i.addr)
					`LMSFC_ADDR_BRT_LO: rdata_o <= brt_lo_q;
					`LMSFC_ADDR_BRT_HI: rdata_o <= brt_hi_q;
					`LMSFC_ADDR_SCAN: rdata_o <= {7'h00, scan_q};
					default: rdata_o <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// slot counter: two slots of 1400 ticks make 2800
	assign slot_end = mux_tick && slot_cnt_q == 11'(`LMSFC_SLOT_CYCLES - 1);
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			slot_cnt_q <= 11'h000;
		end else if (mux_tick) begin
			slot_cnt_q <= slot_end ? 11'h000 : slot_cnt_q + 11'h001;
		end
	end
	// pairs alternate each slot; two-digit scan uses pair A every slot
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			slot_q <= lmsfc_pkg::LMSFC_SLOT_A;
		end else if (slot_end) begin
			case (slot_q)
				lmsfc_pkg::LMSFC_SLOT_A: slot_q <= act_scan_q ? lmsfc_pkg::LMSFC_SLOT_B
					: lmsfc_pkg::LMSFC_SLOT_A;
				lmsfc_pkg::LMSFC_SLOT_B: slot_q <= lmsfc_pkg::LMSFC_SLOT_A;
				default: slot_q <= lmsfc_pkg::LMSFC_SLOT_A;
			endcase
		end
	end

	// settings latched only at slot boundaries
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			act_scan_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				act_brt_q[i] <= 4'h0;
			end
		end else if (slot_end) begin
			act_scan_q   <= scan_q;
			act_brt_q[0] <= brt_lo_q[3:0];
			act_brt_q[1] <= brt_lo_q[7:4];
			act_brt_q[2] <= brt_hi_q[3:0];
			act_brt_q[3] <= brt_hi_q[7:4];
		end
	end

	////////////////////////////////////////////////////////////////////
	// step within slot: 16 steps, nibble n lights n+1 steps, 15 capped
	assign step_now = 4'(slot_cnt_q / 11'(`LMSFC_STEP_CYCLES + 1));
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			digit_en_o <= 4'h0;
		end else begin
			digit_en_o <= 4'h0;
			for (int d = 0; d < 4; d++) begin
				// one modulator per digit
				if ((d / 2) == int'(slot_q) && step_now < on_steps[d]) begin
					digit_en_o[d] <= 1'b1;
				end
			end
		end
	end
	generate
		for (genvar g = 0; g < 4; g++) begin : g_duty
			// top step always blanked
			assign on_steps[g] = (act_brt_q[g] == 4'hf) ? 4'hf : act_brt_q[g] + 4'h1;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// checks
	property p_ptr_load;
		@(posedge clock_i) disable iff (!rst_n_i)
		g_ptr && req_i.data > 8'hf7 |=> ptr_q == 8'h80;
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("bad pointer load");
	property p_ptr_wrap;
		@(posedge clock_i) disable iff (!rst_n_i)
		!g_ptr && g_data && ptr_q == 8'hf7 |=> ptr_q == 8'h80;
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("no pointer wrap");
	property p_ptr_inc;
		@(posedge clock_i) disable iff (!rst_n_i)
		!g_ptr && g_data && ptr_q < 8'hf7 |=> ptr_q == $past(ptr_q) + 8'h01;
	endproperty
	a_ptr_inc: assert property (p_ptr_inc) else $error("no pointer step");
	property p_ptr_hold;
		@(posedge clock_i) disable iff (!rst_n_i)
		!g_ptr && !g_data |=> $stable(ptr_q);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
	property p_rd_msb;
		@(posedge clock_i) disable iff (!rst_n_i)
		g_rd |=> rvalid_o && !rdata_o[7];
	endproperty
	a_rd_msb: assert property (p_rd_msb) else $error("glyph read msb set");
	property p_nop;
		@(posedge clock_i) disable iff (!rst_n_i)
		req_i.wr && req_i.addr == 8'h00 |=> $stable(brt_lo_q) && $stable(brt_hi_q)
			&& $stable(scan_q) && $stable(ptr_q);
	endproperty
	a_nop: assert property (p_nop) else $error("ignored write changed state");
	property p_pair;
		@(posedge clock_i) disable iff (!rst_n_i)
		!(digit_en_o[1:0] != 2'h0 && digit_en_o[3:2] != 2'h0);
	endproperty
	a_pair: assert property (p_pair) else $error("both pairs lit");
	property p_two;
		@(posedge clock_i) disable iff (!rst_n_i)
		!act_scan_q && slot_end |=> slot_q == lmsfc_pkg::LMSFC_SLOT_A;
	endproperty
	a_two: assert property (p_two) else $error("second pair scanned");
	property p_blank;
		@(posedge clock_i) disable iff (!rst_n_i)
		step_now == 4'hf |=> digit_en_o == 4'h0;
	endproperty
	a_blank: assert property (p_blank) else $error("blanking step lit");
	property p_latch;
		@(posedge clock_i) disable iff (!rst_n_i)
		!slot_end |=> $stable(act_scan_q) && $stable(act_brt_q[0]) && $stable(act_brt_q[1])
			&& $stable(act_brt_q[2]) && $stable(act_brt_q[3]);
	endproperty
	a_latch: assert property (p_latch) else $error("setting changed mid slot");
endmodule

// ---- verilog/lmsfc_map.svh ----
// Purpose: register offsets, field positions, reset values and scan counts
// Assumes: included by its bare name from the design
// Notes:   all figures held as defines
`ifndef LMSFC_MAP_SVH
`define LMSFC_MAP_SVH
`define LMSFC_ADDR_NOP       8'h00
`define LMSFC_ADDR_BRT_LO    8'h01
`define LMSFC_ADDR_BRT_HI    8'h02
`define LMSFC_ADDR_SCAN      8'h03
`define LMSFC_ADDR_GLYPH     8'h05
`define LMSFC_SCAN_BIT       0
`define LMSFC_RST_BRT        8'h00
`define LMSFC_RST_SCAN       8'h00
`define LMSFC_PTR_FIRST      8'h80
`define LMSFC_PTR_LAST       8'hf7
`define LMSFC_GLYPH_DEPTH    120
`define LMSFC_SCAN_CYCLES    5600
`define LMSFC_SLOT_CYCLES    1400
`define LMSFC_STEP_CYCLES    87
`endif

// ---- verilog/lmsfc_pkg.sv ----
// Purpose: types for the scan and glyph controller
// Assumes: map header holds the numbers
// Notes:   register access request carried as one struct
package lmsfc_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
	} lmsfc_req_s;
	typedef enum logic [1:0] {
		LMSFC_SLOT_A = 2'b00,
		LMSFC_SLOT_B = 2'b01
	} lmsfc_slot_e;
endpackage

// ---- bench/lmsfc_mux_osc.sv ----
// Purpose: free running multiplex clock source at the pin
// Assumes: 7.8125 MHz, sixteen system clocks per period
// Notes:   phase offset from the system clock on purpose
`timescale 1ns/1ps
module lmsfc_mux_osc (
	// multiplex clock out
	output logic mux_clock_o
);
	////////////////////////////////////////////////////////////////
	// oscillator runs free, kept inside the 1 to 8 MHz band
	initial begin
		mux_clock_o = 1'b0;
		#3;
		forever #64 mux_clock_o = ~mux_clock_o;
	end
endmodule

// ---- bench/testbench.sv ----
// Purpose: register, glyph port and scan checks for the controller
// Assumes: mux clock of sixteen system clocks, so one step is 1408 clocks
// Notes:   widths compared with a small window for synchroniser lag
`timescale 1ns/1ps
module testbench;
	logic                 clock_i;
	logic                 rst_n_i;
	lmsfc_pkg::lmsfc_req_s req_i;
	logic [7:0]           rdata_o;
	logic                 rvalid_o;
	logic                 mux_clk;
	logic [3:0]           digit_en_o;
	int                   bad_count;
	int                   samples_checked;
	int                   cycles;
	int                   w0;
	int                   w1;
	////////////////////////////////////////////////////////////////
	// design and far side
	lmsfc_ctrl lmsfc_ctrl_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .mux_clock_pin_i(mux_clk),
		.digit_en_o(digit_en_o));
	lmsfc_mux_osc lmsfc_mux_osc_inst (.mux_clock_o(mux_clk));
	// clock and watchdog
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 90000) begin
			bad_count++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////
	// compares and access tasks
	task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmpw(input string n, input int e, input int g);
		samples_checked++;
		if (g < e - 24 || g > e + 24) begin
			bad_count++;
			$display("unexpected %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i) req_i <= {1'b1, 1'b0, a, d};
		@(posedge clock_i) req_i <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_i) req_i <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clock_i) req_i <= '0;
		#1;
		cmp8("rvalid", 8'h01, {7'h00, rvalid_o});
		cmp8("rdata", e, rdata_o);
	endtask
	task complete_run();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_n_i = 1'b0;
		req_i = '0;
		repeat (10) @(posedge clock_i);
		#1 cmp8("digits in reset", 8'h00, {4'h0, digit_en_o});
		@(posedge clock_i) rst_n_i <= 1'b1;
		wr(8'h05, 8'h8a);
		wr(8'h05, 8'h42);
		wr(8'h05, 8'h61);
		wr(8'h05, 8'h8a);
		rd(8'h05, 8'h42);
		rd(8'h05, 8'h61);
		wr(8'h05, 8'hf7);
		wr(8'h05, 8'h55);
		wr(8'h05, 8'h7f);
		wr(8'h05, 8'hfc);
		rd(8'h05, 8'h7f);
		wr(8'h05, 8'hf7);
		rd(8'h05, 8'h55);
		rd(8'h05, 8'h7f);
		for (int g = 0; g < 24; g++) begin
			wr(8'h05, 8'h80 + 8'(5 * g));
			for (int c = 0; c < 5; c++) wr(8'h05, 8'(5 * g + c));
		end
		for (int g = 0; g < 24; g++) begin
			wr(8'h05, 8'h80 + 8'(5 * g));
			for (int c = 0; c < 5; c++) rd(8'h05, 8'(5 * g + c));
		end
		$display("glyph port test done");
		wr(8'h01, 8'h30);
		wr(8'h00, 8'hff);
		rd(8'h01, 8'h30);
		rd(8'h04, 8'h00);
		wr(8'h02, 8'h0e);
		wr(8'h03, 8'h01);
		$display("register test done");
		while (digit_en_o[2] !== 1'b1) @(posedge clock_i) #1;
		w0 = 0;
		while (digit_en_o[2] === 1'b1) begin
			w0++;
			@(posedge clock_i) #1;
		end
		cmpw("digit2 width", 15 * 1408, w0);
		while (digit_en_o[0] !== 1'b1) @(posedge clock_i) #1;
		#1 cmp8("pair enables", 8'h03, {4'h0, digit_en_o});
		w0 = 0;
		w1 = 0;
		while (digit_en_o[1:0] !== 2'b00) begin
			w0 += (digit_en_o[0] === 1'b1);
			w1 += (digit_en_o[1] === 1'b1);
			@(posedge clock_i) #1;
		end
		cmpw("digit0 width", 1408, w0);
		cmpw("digit1 width", 4 * 1408, w1);
		$display("scan test done");
		complete_run();
	end
endmodule
